//--- bench/mni_mii_mac_sva.sv
// checker for the mii mac pins
`timescale 1ns/1ps
`default_nettype none
module mni_mii_mac_sva (
    // clocks and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_tx_clk,
    // watched pins
    input wire logic [3:0] o_txd,
    input wire logic o_tx_en,
    input wire logic o_tx_er,
    input wire logic i_col,
    input wire logic i_crs,
    input wire logic i_port_sel,
    input wire logic o_collision,
    input wire logic o_carrier
);
    // ==========
    // cycles since the last raw transmit clock rise
    logic tclk_ff;
    logic [3:0] cnt_ff;
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            {tclk_ff, cnt_ff} <= 5'h0F;
        else
            {tclk_ff, cnt_ff} <= {i_tx_clk, (i_tx_clk && !tclk_ff) ? 4'h0 : cnt_ff + 4'h1};
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    // ==========
    // assertions
    sequence s_col; (i_port_sel && i_col) [*8]; endsequence
    sequence s_crs; (i_port_sel && i_crs) [*8]; endsequence
    sequence s_off; !i_port_sel [*8]; endsequence
    property p_er; !o_tx_er; endproperty
    a_er: assert property (p_er) else $error("tx er high");
    property p_idle; !o_tx_en |-> o_txd == 4'h0; endproperty
    a_idle: assert property (p_idle) else $error("txd not zero");
    // sync delay puts every change a few cycles after the rise
    property p_step; $changed({o_tx_en, o_txd}) |-> cnt_ff inside {[1:6]}; endproperty
    a_step: assert property (p_step) else $error("tx pins off step");
    property p_en; $rose(o_tx_en) |=> o_tx_en [*8]; endproperty
    a_en: assert property (p_en) else $error("tx en short");
    property p_nib; o_tx_en && $changed(o_txd) |=> $stable(o_txd) [*5]; endproperty
    a_nib: assert property (p_nib) else $error("nibble short");
    property p_col; s_col |-> o_collision; endproperty
    a_col: assert property (p_col) else $error("collision lost");
    property p_crs; s_crs |-> o_carrier; endproperty
    a_crs: assert property (p_crs) else $error("carrier lost");
    property p_off; s_off |-> !o_collision && !o_carrier; endproperty
    a_off: assert property (p_off) else $error("unselected port seen");
endmodule : mni_mii_mac_sva
bind mni_mii_mac mni_mii_mac_sva u_mni_mii_mac_sva (.i_core_clk, .i_rst_n, .i_tx_clk,
    .o_txd, .o_tx_en, .o_tx_er, .i_col, .i_crs, .i_port_sel, .o_collision, .o_carrier);
`default_nettype wire

//--- bench/mni_mii_mac_tb.sv
// testbench for the mii mac
`timescale 1ns/1ps
`default_nettype none
module mni_mii_mac_tb;
    import mni_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_col = 1'b0;
    logic i_crs = 1'b0;
    logic i_port_sel = 1'b1;
    logic i_tx_valid = 1'b0;
    mni_tx_byte_s i_tx_byte = '0;
    mni_rx_byte_s o_rx_byte;
    mni_rx_byte_s bq [$];
    wire logic i_tx_clk, i_rx_clk, o_tx_en, o_tx_er, o_tx_ready, o_rx_valid, o_collision;
    wire logic o_carrier, m_dv, m_er;
    wire logic [3:0] o_txd, m_rxd;
    // unselected port leaves the receive lines floating
    wire logic [3:0] i_rxd = i_port_sel ? m_rxd : 4'hZ;
    wire logic i_rx_dv = i_port_sel ? m_dv : 1'bZ;
    wire logic i_rx_er = i_port_sel ? m_er : 1'bZ;
    int n_mismatch = 0;
    int total_checks = 0;
    mni_mii_mac u_mni_mii_mac (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_tx_clk(i_tx_clk),
        .o_txd(o_txd),
        .o_tx_en(o_tx_en),
        .o_tx_er(o_tx_er),
        .i_rx_clk(i_rx_clk),
        .i_rxd(i_rxd),
        .i_rx_dv(i_rx_dv),
        .i_rx_er(i_rx_er),
        .i_col(i_col),
        .i_crs(i_crs),
        .i_port_sel(i_port_sel),
        .i_tx_valid(i_tx_valid),
        .i_tx_byte(i_tx_byte),
        .o_tx_ready(o_tx_ready),
        .o_rx_valid(o_rx_valid),
        .o_rx_byte(o_rx_byte),
        .o_collision(o_collision),
        .o_carrier(o_carrier)
    );
    mni_phy_model u_mni_phy_model (.o_tx_clk(i_tx_clk), .o_rx_clk(i_rx_clk), .i_txd(o_txd),
        .i_tx_en(o_tx_en), .o_rxd(m_rxd), .o_rx_dv(m_dv), .o_rx_er(m_er));
    always #50 i_core_clk = ~i_core_clk;
    // sampled mid-cycle, where the one-cycle pulse has settled
    always @(negedge i_core_clk) if (o_rx_valid === 1'b1) bq.push_back(o_rx_byte);
    // ==========
    // shared tasks
    task automatic chk(input string nm, input logic [10:0] ex, input logic [10:0] got);
        total_checks++;
        if (got !== ex)
        begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, ex, got);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    task automatic put(input logic [7:0] b, input logic last);
        int n;
        n = 0;
        @(negedge i_core_clk);
        i_tx_valid = 1'b1;
        i_tx_byte = {b, last};
        while (o_tx_ready !== 1'b1 && n < 200)
        begin
            @(negedge i_core_clk);
            n++;
        end
        chk("tx ready", 11'h1, 11'(o_tx_ready));
        // byte is taken at the rise between these two falling edges
        @(negedge i_core_clk);
        i_tx_valid = 1'b0;
    endtask : put
    // ==========
    // scenarios
    task automatic t_tx;
        logic [15:0] e;
        e = 16'h3CA5;
        put(8'hA5, 1'b0);
        put(8'h3C, 1'b1);
        for (int n = 0; n < 300 && o_tx_en !== 1'b0; n++) @(posedge i_core_clk);
        @(negedge i_core_clk);
        chk("txd idle", 11'h0, 11'(o_txd));
        chk("tx er", 11'h0, 11'(o_tx_er));
        chk("nibbles", 11'h4, 11'(u_mni_phy_model.tq.size()));
        for (int k = 0; k < 4; k++)
            chk("nibble", 11'(e[4*k +: 4]), 11'(u_mni_phy_model.tq[k]));
        $display("t_tx done");
    endtask : t_tx
    task automatic t_rx(input logic er);
        bq = {};
        u_mni_phy_model.frame(16'h3CA5, er);
        for (int n = 0; n < 600 && bq.size() < 3; n++) @(posedge i_core_clk);
        @(negedge i_core_clk);
        chk("beats", 11'h3, 11'(bq.size()));
        chk("byte0", {8'hA5, 2'b10, 1'b0}, {bq[0][10:1], 1'b0});
        chk("byte1", {8'h3C, 2'b00, 1'b0}, {bq[1][10:1], 1'b0});
        chk("eof", {8'h00, 2'b01, er}, bq[2]);
        $display("t_rx done");
    endtask : t_rx
    task automatic t_sel;
        i_port_sel = 1'b0;
        i_col = 1'b1;
        i_crs = 1'b1;
        bq = {};
        u_mni_phy_model.frame(16'h1234, 1'b0);
        repeat (80) @(negedge i_core_clk);
        chk("unsel beats", 11'h0, 11'(bq.size()));
        chk("unsel col", 11'h0, 11'(o_collision));
        chk("unsel crs", 11'h0, 11'(o_carrier));
        i_port_sel = 1'b1;
        repeat (10) @(negedge i_core_clk);
        chk("col", 11'h1, 11'(o_collision));
        chk("crs", 11'h1, 11'(o_carrier));
        $display("t_sel done");
    endtask : t_sel
    task automatic t_rst;
        // mid-run reset with collision and carrier still present
        @(negedge i_core_clk);
        i_rst_n = 1'b0;
        @(negedge i_core_clk);
        chk("rst col", 11'h0, 11'({o_collision, o_carrier}));
        chk("rst tx", 11'h0, 11'({o_tx_ready, o_tx_en, o_txd}));
        chk("rst rx", 11'h0, 11'(o_rx_valid));
        i_rst_n = 1'b1;
        repeat (10) @(negedge i_core_clk);
        chk("rst crs", 11'h1, 11'(o_carrier));
        chk("rst tx en", 11'h0, 11'(o_tx_en));
        $display("t_rst done");
    endtask : t_rst
    initial
    begin
        repeat (20) @(negedge i_core_clk);
        i_rst_n = 1'b1;
        t_tx;
        t_rx(1'b0);
        t_rx(1'b1);
        t_sel;
        t_rst;
        end_of_test;
    end
    initial
    begin
        #3000000;
        n_mismatch++;
        end_of_test;
    end
endmodule : mni_mii_mac_tb
`default_nettype wire

//--- bench/mni_phy_model.sv
// phy model: nibble clocks, tx capture, rx replay
`timescale 1ns/1ps
`default_nettype none
module mni_phy_model (
    // clocks
    output logic o_tx_clk,
    output logic o_rx_clk,
    // transmit side
    input wire logic [3:0] i_txd,
    input wire logic i_tx_en,
    // receive side
    output logic [3:0] o_rxd,
    output logic o_rx_dv,
    output logic o_rx_er
);
    logic [3:0] tq [$];
    logic [4:0] rq [$];
    // ==========
    // free running clocks, phases unrelated to the core
    initial
    begin
        {o_tx_clk, o_rx_clk, o_rx_dv, o_rx_er, o_rxd} = 8'h06;
        fork
            #37 forever #400 o_tx_clk = ~o_tx_clk;
            #213 forever #400 o_rx_clk = ~o_rx_clk;
        join
    end
    always @(posedge o_tx_clk) if (i_tx_en) tq.push_back(i_txd);
    // ==========
    // one process drives all rx lines, so no same-edge race
    always @(posedge o_rx_clk)
    begin
        if (rq.size() > 0)
            {o_rx_dv, o_rx_er, o_rxd} <= {1'b1, rq.pop_front()};
        else
            {o_rx_dv, o_rx_er, o_rxd} <= {2'b01, ~o_rxd}; // noise when idle
    end
    task automatic frame(input logic [15:0] d, input logic er);
        for (int k = 0; k < 4; k++)
            rq.push_back({er && k == 1, d[4*k +: 4]});
    endtask : frame
endmodule : mni_phy_model
`default_nettype wire

//--- design/mni_mii_mac.sv
// mac-side mii nibble transmit and receive logic
`timescale 1ns/1ps
`default_nettype none
module mni_mii_mac
    import mni_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // mii transmit pins
    input wire logic i_tx_clk,
    output logic [3:0] o_txd,
    output logic o_tx_en,
    output logic o_tx_er,
    // mii receive pins
    input wire logic i_rx_clk,
    input wire logic [3:0] i_rxd,
    input wire logic i_rx_dv,
    input wire logic i_rx_er,
    input wire logic i_col,
    input wire logic i_crs,
    // port selection
    input wire logic i_port_sel,
    // user transmit stream
    input wire logic i_tx_valid,
    input wire mni_pkg::mni_tx_byte_s i_tx_byte,
    output logic o_tx_ready,
    // user receive stream
    output logic o_rx_valid,
    output mni_pkg::mni_rx_byte_s o_rx_byte,
    // line status
    output logic o_collision,
    output logic o_carrier
);
    import mni_pkg::*;

    // ======================================================
    // synchronisers; rx data sampled the same way as its clock
    localparam int SW = 9;
    logic [SW-1:0] sync_out;
    mni_sync #(.W(SW)) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_async({i_tx_clk, i_rx_clk, i_rx_dv, i_rx_er, i_rxd, i_col}),
        .o_sync(sync_out)
    );
    logic txc_s, rxc_s, rxdv_s, rxer_s, col_s;
    logic [3:0] rxd_s;
    assign {txc_s, rxc_s, rxdv_s, rxer_s, rxd_s, col_s} = sync_out;

    logic crs_s;
    mni_sync #(.W(1)) u_sync_crs (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_crs),
        .o_sync(crs_s)
    );

    logic txc_d_ff, rxc_d_ff;
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            txc_d_ff <= 1'b0;
            rxc_d_ff <= 1'b0;
        end
        else
        begin
            txc_d_ff <= txc_s;
            rxc_d_ff <= rxc_s;
        end
    end
    // one-cycle enables on each link clock rise
    logic tx_rise, rx_rise;
    assign tx_rise = txc_s & ~txc_d_ff;
    assign rx_rise = rxc_s & ~rxc_d_ff;

    // ======================================================
    // transmit: one byte buffered, split low nibble first
    mni_tx_e tx_st_ff;
    logic [7:0] tx_hold_ff;
    logic tx_last_ff;
    logic tx_full_ff;
    logic [3:0] tx_hi_ff;
    logic tx_end_ff;
    logic tx_take;
    logic tx_use;
    assign tx_take = o_tx_ready & i_tx_valid;
    // idle needs one rise with enable low, so back-to-back frames stay apart
    assign tx_use = tx_rise & tx_full_ff
        & ((tx_st_ff == TX_LO) | ((tx_st_ff == TX_IDLE) & ~o_tx_en));

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tx_st_ff <= TX_IDLE;
            tx_hold_ff <= 8'h00;
            tx_last_ff <= 1'b0;
            tx_full_ff <= 1'b0;
            tx_hi_ff <= 4'h0;
            tx_end_ff <= 1'b0;
            o_tx_ready <= 1'b0;
            o_txd <= TXD_IDLE;
            o_tx_en <= 1'b0;
        end
        else
        begin
            // byte waits here until a low-nibble rise takes it
            if (tx_take)
            begin
                tx_hold_ff <= i_tx_byte.data;
                tx_last_ff <= i_tx_byte.last;
            end
            if (tx_take)
                tx_full_ff <= 1'b1;
            else if (tx_use)
                tx_full_ff <= 1'b0;
            o_tx_ready <= ~(tx_take | (tx_full_ff & ~tx_use));
            // pins only move on a transmit clock rise
            if (tx_rise)
            begin
                case (tx_st_ff)
                    TX_IDLE, TX_LO:
                    begin
                        if (tx_use)
                        begin
                            o_txd <= tx_hold_ff[3:0];
                            o_tx_en <= 1'b1;
                            tx_hi_ff <= tx_hold_ff[7:4];
                            tx_end_ff <= tx_last_ff;
                            tx_st_ff <= TX_HI;
                        end
                        else
                        begin
                            // late refill ends the frame
                            o_txd <= TXD_IDLE;
                            o_tx_en <= 1'b0;
                            tx_st_ff <= TX_IDLE;
                        end
                    end
                    TX_HI:
                    begin
                        o_txd <= tx_hi_ff;
                        tx_st_ff <= tx_end_ff ? TX_IDLE : TX_LO;
                    end
                    default:
                    begin
                        tx_st_ff <= TX_IDLE;
                    end
                endcase
            end
        end
    end

    // error output reserved, held low
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_tx_er <= TX_ER_VAL;
        else
            o_tx_er <= TX_ER_VAL;
    end

    // ======================================================
    // receive: assemble bytes low nibble first
    logic rx_half_ff, rx_inframe_ff, rx_err_ff, rx_first_ff;
    logic [3:0] rx_lo_ff;
    logic rx_live;
    // unused port ignores floating pins entirely
    assign rx_live = i_port_sel & rx_rise;

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rx_half_ff <= 1'b0;
            rx_inframe_ff <= 1'b0;
            rx_err_ff <= 1'b0;
            rx_first_ff <= 1'b0;
            rx_lo_ff <= 4'h0;
            o_rx_valid <= 1'b0;
            o_rx_byte <= '0;
        end
        else
        begin
            o_rx_valid <= 1'b0;
            if (rx_live && rxdv_s)
            begin
                // data only captured while valid
                rx_inframe_ff <= 1'b1;
                if (!rx_inframe_ff)
                    rx_first_ff <= 1'b1;
                if (rxer_s)
                    rx_err_ff <= 1'b1;
                if (!rx_half_ff)
                    rx_lo_ff <= rxd_s;
                else
                begin
                    o_rx_valid <= 1'b1;
                    o_rx_byte.data <= {rxd_s, rx_lo_ff};
                    o_rx_byte.sof <= rx_first_ff;
                    o_rx_byte.eof <= 1'b0;
                    o_rx_byte.crc_err <= rx_err_ff | rxer_s;
                    rx_first_ff <= 1'b0;
                end
                rx_half_ff <= ~rx_half_ff;
            end
            else if (rx_live && rx_inframe_ff)
            begin
                // frame end: marker beat; error outside valid ignored
                o_rx_valid <= 1'b1;
                o_rx_byte.data <= 8'h00;
                o_rx_byte.sof <= 1'b0;
                o_rx_byte.eof <= 1'b1;
                o_rx_byte.crc_err <= rx_err_ff | rx_half_ff;
                rx_inframe_ff <= 1'b0;
                rx_half_ff <= 1'b0;
                rx_err_ff <= 1'b0;
            end
        end
    end

    // ======================================================
    // line status
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_collision <= 1'b0;
            o_carrier <= 1'b0;
        end
        else
        begin
            o_collision <= i_port_sel & col_s;
            o_carrier <= i_port_sel & crs_s;
        end
    end
endmodule : mni_mii_mac
`default_nettype wire

//--- design/mni_pkg.sv
// package: constants and carriers for the mii nibble interface
// Function
// - while transmit enable is high a valid nibble is presented for every transmit clock rise.
// - while transmit enable is low the four transmit data lines are held at zero.
// - transmit enable rises with the first preamble nibble and drops before the edge after the last nibble.
// - transmit enable, data and error change only in step with transmit clock rises.
// - the transmit error output is always driven to zero.
// - an asserted collision input is reported as a collision for the current transfer. The code reports it only while i_port_sel is high.
// - an asserted carrier sense input is reported as carrier present. The code reports it only while i_port_sel is high.
// - receive data is captured on every receive clock rise while data valid is high, else ignored.
// - the block works correctly with the receive data lines floating when the port is unused.
// - receive error while data valid flags a crc error for the frame, and is ignored otherwise.
package mni_pkg;
    // ======================================================
    // widths and reset values
    localparam int NIB_W = 4;
    localparam int BYTE_W = 8;
    localparam logic [3:0] TXD_IDLE = 4'h0;
    localparam logic TX_ER_VAL = 1'b0;
    // ======================================================
    // carriers
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } mni_tx_byte_s;
    typedef struct packed {
        logic [7:0] data;
        logic sof;
        logic eof;
        logic crc_err;
    } mni_rx_byte_s;
    typedef enum logic [1:0] {TX_IDLE, TX_LO, TX_HI} mni_tx_e;
endpackage : mni_pkg

//--- design/mni_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module mni_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // data
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    // ======================================================
    // stage one read only by stage two
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            o_sync <= '0;
        end
        else
        begin
            s1_ff <= i_async;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (int i = 0; i < W; i++)
            begin
                if (s2_ff[i] == s3_ff[i])
                    o_sync[i] <= s3_ff[i];
            end
        end
    end
endmodule : mni_sync
`default_nettype wire
